// ===== design/msg_link_host.sv
// host end of the message link: master on the out port, slave on the in port
`timescale 1ns/10ps
// What this block does
// - master raises request, slave raises ready
// - command driven after ready; captured on valid
// - master pauses while ready low, resumes after
// - valid marks each word; master may idle
// - last flag with valid; then link idle
// - channel tag held command through last word
// - no waits needed; unlimited data words
// - one command then at least one word
// - command in low byte, rest ignored
// - initiator sends read request with parameters
// - both ports share one link clock, apart from the user clock
// - errors any time; abort alone ends message
// - error lines hold valid code until changed
// - error codes zero to four
// - same error duties on every port, except the host drives no error lines on the in port
// - either side may abort with valid code, except the host on the in port
// - abort codes zero to seven
// - abort only during request; held till drop
module msg_link_host
    import msg_link_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int CHAN_W = 8
) (
    // system clock and reset
    input  wire logic                            clk,
    input  wire logic                            sys_rst,
    // link clock shared by both ports
    input  wire logic                            link_clk,
    // user words to send; first word of a message is the command
    input  wire logic                            tx_valid,
    input  wire logic [DATA_W-1:0]               tx_data,
    input  wire logic                            tx_last,
    input  wire logic [CHAN_W-1:0]               tx_chan,
    output logic                                 tx_ready,
    // user error and abort codes
    input  wire logic                            ctl_valid,
    input  wire logic [msg_link_pkg::CODE_W-1:0] ctl_err,
    input  wire logic [msg_link_pkg::CODE_W-1:0] ctl_abort,
    output logic                                 ctl_ready,
    // words received on the in port
    output logic                                 rx_valid,
    output logic                                 rx_cmd,
    output logic                                 rx_last,
    output logic      [DATA_W-1:0]               rx_data,
    output logic      [CHAN_W-1:0]               rx_chan,
    // status seen from the link
    output logic                                 link_busy,
    output logic      [msg_link_pkg::CODE_W-1:0] dev_out_err,
    output logic      [msg_link_pkg::CODE_W-1:0] dev_out_abort,
    output logic      [msg_link_pkg::CODE_W-1:0] dev_in_err,
    output logic      [msg_link_pkg::CODE_W-1:0] dev_in_abort,
    // out port, host is master
    output logic                                 out_xfer_req,
    output logic                                 out_valid,
    output logic                                 out_last,
    output logic      [DATA_W-1:0]               out_data,
    output logic      [CHAN_W-1:0]               out_chan,
    output logic      [msg_link_pkg::CODE_W-1:0] out_err,
    output logic      [msg_link_pkg::CODE_W-1:0] out_abort,
    input  wire logic                            out_ready,
    input  wire logic [msg_link_pkg::CODE_W-1:0] out_dev_err,
    input  wire logic [msg_link_pkg::CODE_W-1:0] out_dev_abort,
    // in port, host is slave
    input  wire logic                            in_xfer_req,
    input  wire logic                            in_valid,
    input  wire logic                            in_last,
    input  wire logic [DATA_W-1:0]               in_data,
    input  wire logic [CHAN_W-1:0]               in_chan,
    input  wire logic [msg_link_pkg::CODE_W-1:0] in_err,
    input  wire logic [msg_link_pkg::CODE_W-1:0] in_abort,
    output logic                                 in_ready
);

    // ***********************
    // widths and declarations
    // ***********************
    localparam int TXW = DATA_W + CHAN_W + 1;
    localparam int RXW = DATA_W + CHAN_W + 2;
    localparam int CTW = 2 * CODE_W;
    localparam int STW = 4 * CODE_W;

    logic [1:0]        lrst_q;
    wire               link_rst = lrst_q[1];
    logic              tx_pv;
    logic [TXW-1:0]    tx_pw;
    logic              ct_dv;
    logic [CTW-1:0]    ct_w;
    logic              rx_src_rdy;
    logic              rx_dv;
    logic [RXW-1:0]    rx_w;
    logic              st_rdy;
    logic              st_dv;
    logic [STW-1:0]    st_w;
    logic              tx_take;
    logic              rx_have;
    logic              st_chg;
    logic [STW-1:0]    st_now;
    mst_state_t        st_q;
    logic              cmd_q;
    logic              flush_q;
    logic [CODE_W-1:0] abt_req_q;
    logic [STW-1:0]    sent_q;
    logic [RXW-1:0]    rx_mem [RX_DEPTH];
    logic              wr_q;
    logic              rd_q;
    logic [1:0]        cnt_q;
    logic              first_q;

    // ***********************
    // link reset
    // ***********************
    // asserts at once, releases on the link clock edge
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lrst_q <= 2'h3;
        end else begin
            lrst_q <= {lrst_q[0], 1'b0};
        end
    end

    // ***********************
    // crossings
    // ***********************
    // ports run apart from the user clock
    word_xfer #(.W(TXW)) u_tx (
        .src_clk (clk), .src_rst (sys_rst), .src_valid (tx_valid),
        .src_data ({tx_last, tx_chan, tx_data}), .src_ready (tx_ready),
        .dst_clk (link_clk), .dst_rst (link_rst), .dst_valid (tx_pv),
        .dst_data (tx_pw), .dst_take (tx_take)
    );
    word_xfer #(.W(CTW)) u_ctl (
        .src_clk (clk), .src_rst (sys_rst), .src_valid (ctl_valid),
        .src_data ({ctl_abort, ctl_err}), .src_ready (ctl_ready),
        .dst_clk (link_clk), .dst_rst (link_rst), .dst_valid (ct_dv),
        .dst_data (ct_w), .dst_take (ct_dv)
    );
    word_xfer #(.W(RXW)) u_rx (
        .src_clk (link_clk), .src_rst (link_rst), .src_valid (rx_have),
        .src_data (rx_mem[rd_q]), .src_ready (rx_src_rdy),
        .dst_clk (clk), .dst_rst (sys_rst), .dst_valid (rx_dv),
        .dst_data (rx_w), .dst_take (rx_dv)
    );
    word_xfer #(.W(STW)) u_sts (
        .src_clk (link_clk), .src_rst (link_rst), .src_valid (st_chg),
        .src_data (st_now), .src_ready (st_rdy),
        .dst_clk (clk), .dst_rst (sys_rst), .dst_valid (st_dv),
        .dst_data (st_w), .dst_take (st_dv)
    );
    sync2 #(.W(1)) u_busy (
        .clk (clk), .rst (sys_rst), .d (out_xfer_req), .q (link_busy)
    );

    // ***********************
    // out port decode
    // ***********************
    wire               tx_plast = tx_pw[TXW-1];
    wire [CHAN_W-1:0]  tx_pchan = tx_pw[DATA_W +: CHAN_W];
    wire [DATA_W-1:0]  tx_pdata = tx_pw[DATA_W-1:0];
    // command byte in low lane, upper bits zeroed
    wire [DATA_W-1:0]  cmd_word = {{(DATA_W-CMD_W){1'b0}},
                                   tx_pdata[CMD_W-1:0]};
    wire [CODE_W-1:0]  ct_err   = ct_w[CODE_W-1:0];
    wire [CODE_W-1:0]  ct_abt   = ct_w[CTW-1:CODE_W];

    wire in_msg  = st_q == M_SEND;
    wire dev_abt = in_msg & (out_dev_abort != ABT_NONE);
    wire own_abt = in_msg & (abt_req_q != ABT_NONE);
    wire quit    = dev_abt | own_abt;
    // word after each sampled ready, no limit
    wire send    = in_msg & tx_pv & out_ready & ~quit;
    // a last mark on the command word is ignored
    wire is_end  = send & tx_plast & ~cmd_q;
    wire start   = (st_q == M_IDLE) & tx_pv & ~out_xfer_req & ~flush_q;
    wire drop    = flush_q & tx_pv;
    assign tx_take = send | drop;

    // ***********************
    // out port master
    // ***********************
    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            st_q         <= M_IDLE;
            cmd_q        <= 1'b1;
            flush_q      <= 1'b0;
            out_xfer_req <= 1'b0;
            out_valid    <= 1'b0;
            out_last     <= 1'b0;
            out_data     <= '0;
            out_chan     <= '0;
            out_abort    <= ABT_NONE;
        end else begin
            case (st_q)
                M_IDLE: begin
                    out_valid    <= 1'b0;
                    out_last     <= 1'b0;
                    out_xfer_req <= start;
                    if (start) begin
                        // tag stands until the last word
                        out_chan <= tx_pchan;
                        cmd_q    <= 1'b1;
                        st_q     <= M_SEND;
                    end
                end
                M_SEND: begin
                    out_valid <= send;
                    // last rides with the final valid
                    out_last  <= is_end;
                    if (send) begin
                        out_data <= cmd_q ? cmd_word : tx_pdata;
                        cmd_q    <= 1'b0;
                    end
                    // request drops the cycle after last
                    if (is_end) begin
                        st_q <= M_IDLE;
                    end
                    // host or device ends the message early
                    if (quit) begin
                        out_abort <= own_abt ? abt_req_q : ABT_NONE;
                        st_q      <= M_ABORT;
                    end
                end
                M_ABORT: begin
                    // abort code and request fall together
                    out_xfer_req <= 1'b0;
                    out_valid    <= 1'b0;
                    out_last     <= 1'b0;
                    out_abort    <= ABT_NONE;
                    flush_q      <= 1'b1;
                    st_q         <= M_IDLE;
                end
                default: begin
                    st_q <= M_IDLE;
                end
            endcase
            // rest of an aborted message is thrown away
            if (drop & tx_plast) begin
                flush_q <= 1'b0;
            end
        end
    end

    // ***********************
    // host error and abort codes
    // ***********************
    // codes past the table are refused
    wire err_ok = ct_dv & (ct_err <= ERR_MAX);
    // abort codes past the table are refused
    // an abort outside a message is ignored
    wire abt_ok = ct_dv & (ct_abt <= ABT_MAX) & in_msg;

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            out_err   <= ERR_NONE;
            abt_req_q <= ABT_NONE;
        end else begin
            // code held until software changes it
            if (err_ok) begin
                out_err <= ct_err;
            end
            // request is one-shot, spent when the abort fires
            if (abt_ok) begin
                abt_req_q <= ct_abt;
            end else if (st_q != M_SEND) begin
                abt_req_q <= ABT_NONE;
            end
        end
    end

    // ***********************
    // in port slave
    // ***********************
    // a valid while request is high is captured unless both slots are full
    wire            cap     = in_xfer_req & in_valid & (cnt_q != RX_FULL);
    assign rx_have = cnt_q != RX_EMPTY;
    wire            pop     = rx_have & rx_src_rdy;
    wire [1:0]      cnt_d   = cnt_q + {1'b0, cap} - {1'b0, pop};
    wire [RXW-1:0]  cap_w   = {first_q, in_last, in_chan, in_data};

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            cnt_q    <= RX_EMPTY;
            first_q  <= 1'b1;
            in_ready <= 1'b0;
        end else begin
            if (cap) begin
                rx_mem[wr_q] <= cap_w;
                wr_q         <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_d;
            // ready may stand before any request
            // two slots cover the word sent on a stale ready
            in_ready <= cnt_d == RX_EMPTY;
            // first word of each message is the command
            if (~in_xfer_req) begin
                first_q <= 1'b1;
            end else if (cap) begin
                first_q <= 1'b0;
            end
        end
    end

    // ***********************
    // link status to user
    // ***********************
    // errors pass at any time, on both ports
    assign st_now = {out_dev_err, out_dev_abort, in_err, in_abort};
    assign st_chg = st_now != sent_q;

    always_ff @(posedge link_clk or posedge link_rst) begin
        if (link_rst) begin
            sent_q <= '0;
        end else if (st_chg & st_rdy) begin
            sent_q <= st_now;
        end
    end

    // ***********************
    // user side registers
    // ***********************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_valid      <= 1'b0;
            rx_cmd        <= 1'b0;
            rx_last       <= 1'b0;
            rx_data       <= '0;
            rx_chan       <= '0;
            dev_out_err   <= ERR_NONE;
            dev_out_abort <= ABT_NONE;
            dev_in_err    <= ERR_NONE;
            dev_in_abort  <= ABT_NONE;
        end else begin
            rx_valid <= rx_dv;
            if (rx_dv) begin
                // read responses arrive on this port
                rx_cmd  <= rx_w[RXW-1];
                rx_last <= rx_w[RXW-2];
                rx_chan <= rx_w[DATA_W +: CHAN_W];
                rx_data <= rx_w[DATA_W-1:0];
            end
            if (st_dv) begin
                dev_out_err   <= st_w[3*CODE_W +: CODE_W];
                dev_out_abort <= st_w[2*CODE_W +: CODE_W];
                dev_in_err    <= st_w[CODE_W +: CODE_W];
                dev_in_abort  <= st_w[CODE_W-1:0];
            end
        end
    end

endmodule

// ===== design/msg_link_pkg.sv
// shared codes, widths and state types of the message link host
package msg_link_pkg;

    // ***********************
    // widths
    // ***********************
    localparam int CODE_W = 8;
    localparam int CMD_W  = 8;

    // ***********************
    // error codes
    // ***********************
    localparam logic [7:0] ERR_NONE        = 8'h00;
    localparam logic [7:0] ERR_SYSTEM      = 8'h01;
    localparam logic [7:0] ERR_DATA        = 8'h02;
    localparam logic [7:0] ERR_SYNC        = 8'h03;
    localparam logic [7:0] ERR_UNSUPPORTED = 8'h04;
    localparam logic [7:0] ERR_MAX         = ERR_UNSUPPORTED;

    // ***********************
    // abort codes
    // ***********************
    localparam logic [7:0] ABT_NONE      = 8'h00;
    localparam logic [7:0] ABT_SYSTEM    = 8'h01;
    localparam logic [7:0] ABT_DATA      = 8'h02;
    localparam logic [7:0] ABT_REFUSED   = 8'h03;
    localparam logic [7:0] ABT_LOST_DST  = 8'h04;
    localparam logic [7:0] ABT_LOST_SRC  = 8'h05;
    localparam logic [7:0] ABT_SYNC      = 8'h06;
    localparam logic [7:0] ABT_INTERFACE = 8'h07;
    localparam logic [7:0] ABT_MAX       = ABT_INTERFACE;

    // ***********************
    // command codes
    // ***********************
    localparam logic [7:0] CMD_EXT_WRITE = 8'h01;
    localparam logic [7:0] CMD_INT_WRITE = 8'h02;
    localparam logic [7:0] CMD_EXT_READ  = 8'h03;
    localparam logic [7:0] CMD_INT_READ  = 8'h04;
    localparam logic [7:0] CMD_EXT_RESP  = 8'h05;
    localparam logic [7:0] CMD_INT_RESP  = 8'h06;

    // ***********************
    // receive skid store
    // ***********************
    localparam int         RX_DEPTH = 2;
    localparam logic [1:0] RX_FULL  = 2'h2;
    localparam logic [1:0] RX_EMPTY = 2'h0;
    localparam logic [1:0] RX_ONE   = 2'h1;

    typedef enum logic [1:0] {M_IDLE, M_SEND, M_ABORT} mst_state_t;

endpackage

// ===== design/sync2.sv
// two-flop level synchroniser
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 1
) (
    // clock and reset of the reading domain
    input  wire logic         clk,
    input  wire logic         rst,
    // level in and synchronised level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// ===== design/word_xfer.sv
// toggle handshake carrying one word between two clock domains
`timescale 1ns/10ps
module word_xfer #(
    parameter int W = 8
) (
    // source domain
    input  wire logic         src_clk,
    input  wire logic         src_rst,
    input  wire logic         src_valid,
    input  wire logic [W-1:0] src_data,
    output logic              src_ready,
    // destination domain
    input  wire logic         dst_clk,
    input  wire logic         dst_rst,
    output logic              dst_valid,
    output logic      [W-1:0] dst_data,
    input  wire logic         dst_take
);

    logic         req_q;
    logic         ack_q;
    logic [W-1:0] hold_q;
    logic         req_s;
    logic         ack_s;

    wire launch   = src_valid & src_ready;
    // hold_q is stable two edges before the destination reads it
    wire new_word = (req_s != ack_q) & ~dst_valid;
    wire done     = dst_take & dst_valid;

    sync2 #(.W(1)) u_req (
        .clk (dst_clk),
        .rst (dst_rst),
        .d   (req_q),
        .q   (req_s)
    );

    sync2 #(.W(1)) u_ack (
        .clk (src_clk),
        .rst (src_rst),
        .d   (ack_q),
        .q   (ack_s)
    );

    always_ff @(posedge src_clk or posedge src_rst) begin
        if (src_rst) begin
            req_q     <= 1'b0;
            hold_q    <= '0;
            src_ready <= 1'b1;
        end else begin
            if (launch) begin
                hold_q <= src_data;
                req_q  <= ~req_q;
            end
            src_ready <= ~launch & (req_q == ack_s);
        end
    end

    always_ff @(posedge dst_clk or posedge dst_rst) begin
        if (dst_rst) begin
            ack_q     <= 1'b0;
            dst_valid <= 1'b0;
            dst_data  <= '0;
        end else begin
            if (new_word) begin
                dst_data  <= hold_q;
                dst_valid <= 1'b1;
            end else if (done) begin
                dst_valid <= 1'b0;
                ack_q     <= ~ack_q;
            end
        end
    end

endmodule

// ===== test/link_props.sv
// assertions on the host's link ports
`timescale 1ns/10ps
// ****
// link checker
// ****
module link_props
    import msg_link_pkg::*;
#(
    parameter int CHAN_W = 8
) (
    // link clock and reset
    input wire logic                            link_clk,
    input wire logic                            sys_rst,
    // out port
    input wire logic                            out_xfer_req,
    input wire logic                            out_valid,
    input wire logic                            out_last,
    input wire logic [CHAN_W-1:0]               out_chan,
    input wire logic [msg_link_pkg::CODE_W-1:0] out_err,
    input wire logic [msg_link_pkg::CODE_W-1:0] out_abort,
    input wire logic                            out_ready,
    // in port
    input wire logic                            in_xfer_req,
    input wire logic                            in_valid,
    input wire logic                            in_ready
);
    default clocking @(posedge link_clk); endclocking
    default disable iff (sys_rst);

    property p_valid; out_valid |-> out_xfer_req; endproperty
    a_valid: assert property (p_valid)
        else $error("word without request");
    property p_first; $rose(out_xfer_req) |-> !out_valid; endproperty
    a_first: assert property (p_first)
        else $error("command before ready seen");
    property p_wait; !out_ready |=> !out_valid; endproperty
    a_wait: assert property (p_wait)
        else $error("word after ready low");
    property p_last;
        out_valid && out_last |-> out_xfer_req ##1 !out_xfer_req && !out_valid;
    endproperty
    a_last: assert property (p_last)
        else $error("request not dropped after last");
    property p_chan; out_xfer_req && $past(out_xfer_req) |-> $stable(out_chan);
    endproperty
    a_chan: assert property (p_chan)
        else $error("channel tag moved in message");
    property p_abort;
        out_abort != ABT_NONE |-> out_xfer_req && out_abort <= ABT_MAX
            ##1 out_abort == ABT_NONE && !out_xfer_req;
    endproperty
    a_abort: assert property (p_abort)
        else $error("bad abort sequence");
    property p_err_hold; $changed(out_err) |=> $stable(out_err); endproperty
    a_err_hold: assert property (p_err_hold)
        else $error("error code too short");
    property p_err_code; out_err <= ERR_MAX; endproperty
    a_err_code: assert property (p_err_code)
        else $error("invalid error code");
    property p_in_ready; in_xfer_req && in_valid |=> !in_ready; endproperty
    a_in_ready: assert property (p_in_ready)
        else $error("ready kept after capture");
endmodule

bind msg_link_host link_props #(.CHAN_W(CHAN_W)) u_props (.*);

// ===== test/dev_model.sv
// device model: slave on the host's out port, master on its in port
`timescale 1ns/10ps
module dev_model
    import msg_link_pkg::*;
(
    // clock, reset, pacing
    input wire logic        link_clk,
    input wire logic        sys_rst,
    input wire logic        slow,
    // out port of the host
    input wire logic        out_xfer_req,
    input wire logic        out_valid,
    input wire logic        out_last,
    input wire logic [31:0] out_data,
    input wire logic [7:0]  out_chan,
    input wire logic [7:0]  out_err,
    input wire logic [7:0]  out_abort,
    output logic            out_ready,
    output logic     [7:0]  out_dev_err,
    output logic     [7:0]  out_dev_abort,
    // in port of the host
    output logic            in_xfer_req,
    output logic            in_valid,
    output logic            in_last,
    output logic     [31:0] in_data,
    output logic     [7:0]  in_chan,
    output logic     [7:0]  in_err,
    output logic     [7:0]  in_abort,
    input wire logic        in_ready
);
    logic [7:0] cmd_q, chan_q, abt_q, err_q;
    logic [1:0] idx_q;
    logic       first_q, rsp_q;
    int         n_q;
    wire        is_read = cmd_q == CMD_EXT_READ || cmd_q == CMD_INT_READ;
    wire [7:0]  rsp_cmd = cmd_q == CMD_INT_READ ? CMD_INT_RESP : CMD_EXT_RESP;
    assign out_dev_abort = ABT_NONE;
    assign in_chan = 8'h03;
    assign in_err = ERR_NONE;
    assign in_abort = ABT_NONE;
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {out_ready, in_xfer_req, in_valid, in_last, rsp_q} <= 5'h00;
            {cmd_q, chan_q, abt_q, err_q, out_dev_err} <= 40'h0;
            {in_data, idx_q, n_q} <= 0;
            first_q <= 1'b1;
        end else begin
            out_ready <= !slow || !out_ready;
            if (!out_xfer_req) first_q <= 1'b1;
            if (out_abort != ABT_NONE) abt_q <= out_abort;
            if (out_err != ERR_NONE) err_q <= out_err;
            if (out_valid) begin
                first_q <= 1'b0;
                n_q <= first_q ? 0 : n_q + 1;
                if (first_q) {cmd_q, chan_q, abt_q} <= {out_data[7:0], out_chan, 8'h00};
                if (first_q) out_dev_err <= out_data[7:0] > CMD_INT_RESP ?
                    ERR_UNSUPPORTED : ERR_NONE;
                // answer only a completed, unaborted read
                if (out_last && abt_q == ABT_NONE && is_read) rsp_q <= 1'b1;
            end
            // response on the initiator's input port
            if (rsp_q && !in_xfer_req) {in_xfer_req, idx_q, rsp_q} <= 4'h8;
            in_valid <= 1'b0;
            // next word only after ready seen
            if (in_xfer_req && !in_valid && in_ready && !in_last) begin
                in_valid <= 1'b1;
                in_data <= idx_q == 2'h0 ? {24'h0, rsp_cmd} : {30'h0, idx_q};
                in_last <= idx_q == 2'h2;
                idx_q <= idx_q + 2'h1;
            end else in_data <= ~in_data;
            if (in_valid && in_last) {in_xfer_req, in_last} <= 2'h0;
        end
    end
endmodule

// ===== test/tb.sv
// self-checking bench for the message link host
`timescale 1ns/10ps
module tb;
    import msg_link_pkg::*;
    logic        clk, link_clk, sys_rst, slow, tx_valid, tx_last, ctl_valid;
    logic [31:0] tx_data;
    logic [7:0]  tx_chan, ctl_err, ctl_abort;
    wire         tx_ready, ctl_ready, rx_valid, rx_cmd, rx_last, link_busy;
    wire  [31:0] rx_data, out_data, in_data;
    wire  [7:0]  rx_chan, dev_out_err, dev_out_abort, dev_in_err, dev_in_abort;
    wire  [7:0]  out_chan, out_err, out_abort, out_dev_err, out_dev_abort;
    wire  [7:0]  in_chan, in_err, in_abort;
    wire         out_xfer_req, out_valid, out_last, out_ready, in_ready;
    wire         in_xfer_req, in_valid, in_last;
    int          miscompares, tests_run, i;

    msg_link_host u_dut (.*);
    dev_model     u_dev (.*);

    initial begin clk = 0; forever #20 clk = ~clk; end
    initial begin link_clk = 0; #7; forever #80 link_clk = ~link_clk; end
    initial begin #3000000; miscompares++; report_and_stop; end

    // ****
    // helpers
    // ****
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task tmo;
        if (i >= 400) begin miscompares++; report_and_stop; end
    endtask
    task send(input logic [31:0] d, input logic l);
        @(negedge clk); {tx_valid, tx_data, tx_last} = {1'b1, d, l};
        for (i = 0; i < 400 && tx_ready !== 1'b1; i++) @(negedge clk);
        tmo;
        @(negedge clk); tx_valid = 1'b0;
    endtask
    task msg(input logic [7:0] c, input int n);
        send({24'hffffff, c}, 1'b0);
        for (int k = 1; k <= n; k++) send(k, k == n);
    endtask
    task ctl(input logic [7:0] e, input logic [7:0] a);
        @(negedge clk); {ctl_valid, ctl_err, ctl_abort} = {1'b1, e, a};
        for (i = 0; i < 400 && ctl_ready !== 1'b1; i++) @(negedge clk);
        tmo;
        @(negedge clk); ctl_valid = 1'b0;
    endtask

    // ****
    // scenarios
    // ****
    task t_write;
        {slow, tx_chan} = {1'b1, 8'h5a};
        msg(CMD_EXT_WRITE, 3);
        for (i = 0; i < 400 && u_dev.n_q != 3; i++) @(negedge clk);
        tmo;
        chk(u_dev.cmd_q, CMD_EXT_WRITE);
        chk(u_dev.chan_q, 8'h5a);
        chk(u_dev.n_q, 3);
        $display("t_write done");
    endtask
    task t_read;
        slow = 1'b0;
        for (int j = 0; j < 2; j++) begin
            msg(j ? CMD_INT_READ : CMD_EXT_READ, 1);
            for (int w = 0; w < 3; w++) begin
                for (i = 0; i < 400 && rx_valid !== 1'b1; i++) @(negedge clk);
                tmo;
                chk({rx_chan, rx_cmd, rx_last}, {8'h03, w == 0, w == 2});
                chk(rx_data, w ? w : j ? CMD_INT_RESP : CMD_EXT_RESP);
                @(negedge clk);
            end
        end
        $display("t_read done");
    endtask
    task t_unsup;
        msg(8'h0a, 1);
        for (i = 0; i < 400 && dev_out_err !== ERR_UNSUPPORTED; i++)
            @(negedge clk);
        chk(dev_out_err, ERR_UNSUPPORTED);
        chk({dev_out_abort, dev_in_err, dev_in_abort}, 0);
        $display("t_unsup done");
    endtask
    task t_abort;
        int seen;
        seen = 0;
        send({24'h0, CMD_EXT_READ}, 1'b0);
        for (i = 0; i < 400 && link_busy !== 1'b1; i++) @(negedge clk);
        tmo;
        ctl(ERR_NONE, ABT_LOST_SRC);
        send(32'h1, 1'b1);
        for (i = 0; i < 200; i++) begin
            @(negedge clk);
            if (rx_valid === 1'b1) seen++;
        end
        chk(u_dev.abt_q, ABT_LOST_SRC);
        chk(seen, 0);
        chk(link_busy, 1'b0);
        $display("t_abort done");
    endtask
    task t_err;
        for (logic [7:0] e = ERR_SYSTEM; e <= ERR_MAX; e++) begin
            ctl(e, ABT_NONE);
            for (i = 0; i < 400 && u_dev.err_q !== e; i++) @(negedge clk);
            chk(u_dev.err_q, e);
        end
        $display("t_err done");
    endtask

    initial begin
        {sys_rst, slow, tx_valid, tx_last, ctl_valid} = 5'h00;
        #1 sys_rst = 1'b1;
        {tx_data, tx_chan, ctl_err, ctl_abort} = 0;
        miscompares = 0;
        tests_run = 0;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        chk({out_xfer_req, tx_ready}, 2'h1);
        repeat (4) @(negedge clk);
        t_write;
        t_read;
        t_unsup;
        t_abort;
        t_err;
        report_and_stop;
    end
endmodule
